// [dv/rsi_top_bench.sv]
module rsi_top_bench;
    timeunit 1ns;
    timeprecision 100ps;
    // ============================================================
    // stimulus and observed signals
    logic        clk_i   = 1'b0;
    logic        rst_i   = 1'b1;
    logic        wb_cyc  = 1'b0;
    logic        wb_stb  = 1'b0;
    logic        wb_we   = 1'b0;
    logic [9:0]  wb_adr  = 10'h000;
    logic [3:0]  wb_sel  = 4'h0;
    logic [31:0] wb_wdat = 32'h0000_0000;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic [4:0]  evt     = 5'h00;
    logic        sleep   = 1'b0;
    logic [3:0]  irq_src = 4'h0;
    logic [7:0]  pc_low_o;
    logic [6:0]  cause_o;
    logic [31:0] rd_q;
    int          err_total = 0;
    int          checked   = 0;

    always #12.5 clk_i = ~clk_i;

    rsi_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .por_evt_i(evt[4]), .bor_evt_i(evt[3]),
        .wdt_evt_i(evt[2]), .pin_evt_i(evt[1]), .sleep_i(sleep), .wake_irq_i(evt[0]),
        .irq_src_i(irq_src), .pc_low_o(pc_low_o), .cause_o(cause_o));

    // ============================================================
    // shared tasks
    task automatic stop_test;
        $display("checked %0d, err_total %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
        end
    endtask

    // classic single cycle; a missing ack ends the wait and shows as a mismatch
    task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc  <= 1'b1;
        wb_stb  <= 1'b1;
        wb_we   <= w;
        wb_adr  <= {idx, 2'h0};
        wb_sel  <= 4'h1;
        wb_wdat <= {24'h00_0000, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        chk("bus ack", {31'h0, wb_ack_o}, 32'h1);
        rd_q = wb_dat_o;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        xfer(1'b1, idx, d);
    endtask

    task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
        xfer(1'b0, idx, 8'h00);
        chk($sformatf("register %h", idx), rd_q, {24'h00_0000, exp});
    endtask

    // one-cycle event pulse: {por, bor, watchdog, pin, irq wake}
    task automatic ev(input logic [4:0] e, input logic [3:0] src);
        @(posedge clk_i);
        evt     <= e;
        irq_src <= src;
        @(posedge clk_i);
        evt <= 5'h00;
    endtask

    // ============================================================
    // register tables: index, value after reset, read-back after writing ff
    localparam logic [7:0] TIDX [14] = '{rsi_pkg::IDX_PCLO, rsi_pkg::IDX_STAT,
        rsi_pkg::IDX_PCHI, rsi_pkg::IDX_ICTL, rsi_pkg::IDX_PFLG, rsi_pkg::IDX_CMP,
        rsi_pkg::IDX_OPT, rsi_pkg::IDX_DIRA, rsi_pkg::IDX_DIRB, rsi_pkg::IDX_PEN,
        rsi_pkg::IDX_VREF, rsi_pkg::IDX_PWR, rsi_pkg::IDX_INDIR, 8'h50};
    localparam logic [7:0] TRST [14] = '{8'h00, 8'h18, 8'h00, 8'h00, 8'h00, 8'h00,
        8'hff, 8'h1f, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    localparam logic [7:0] TMSK [14] = '{8'hff, 8'hff, 8'h1f, 8'hff, 8'h40, 8'h3f,
        8'hff, 8'h1f, 8'hff, 8'h40, 8'hef, 8'h03, 8'h00, 8'h00};

    initial begin
        repeat (5000) @(posedge clk_i);
        err_total++;
        stop_test();
    end

    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 14; i++) rd(TIDX[i], TRST[i]);
        chk("cause", {25'h0, cause_o}, 32'h01);
        // counter and status are left out: writing ff would change the counter and the writable status bits
        for (int i = 2; i < 14; i++) begin
            wr(TIDX[i], 8'hff);
            rd(TIDX[i], TMSK[i]);
        end
        wr(rsi_pkg::IDX_OPT, 8'h00);
        wr(rsi_pkg::IDX_PCLO, 8'h55);
        wr(rsi_pkg::IDX_TMR, 8'ha5);
        wr(rsi_pkg::IDX_WACC, 8'h5a);
        ev(5'h04, 4'h0);
        rd(rsi_pkg::IDX_PCLO, 8'h00);
        rd(rsi_pkg::IDX_OPT, 8'hff);
        rd(rsi_pkg::IDX_PFLG, 8'h00);
        rd(rsi_pkg::IDX_PWR, 8'h03);
        rd(rsi_pkg::IDX_STAT, 8'h08);
        rd(rsi_pkg::IDX_TMR, 8'ha5);
        rd(rsi_pkg::IDX_WACC, 8'h5a);
        rd(rsi_pkg::IDX_CAUSE, 8'h04);
        chk("cause", {25'h0, cause_o}, 32'h04);
        wr(rsi_pkg::IDX_PCLO, 8'h33);
        ev(5'h02, 4'h0);
        rd(rsi_pkg::IDX_PCLO, 8'h00);
        rd(rsi_pkg::IDX_PWR, 8'h03);
        chk("cause", {25'h0, cause_o}, 32'h08);
        ev(5'h08, 4'h0);
        rd(rsi_pkg::IDX_PWR, 8'h02);
        chk("cause", {25'h0, cause_o}, 32'h02);
        wr(rsi_pkg::IDX_PWR, 8'h03);
        wr(rsi_pkg::IDX_OPT, 8'h00);
        ev(5'h10, 4'h0);
        rd(rsi_pkg::IDX_PWR, 8'h00);
        rd(rsi_pkg::IDX_STAT, 8'h18);
        rd(rsi_pkg::IDX_OPT, 8'hff);
        rd(rsi_pkg::IDX_TMR, 8'h00);
        chk("cause", {25'h0, cause_o}, 32'h01);
        // interrupt and watchdog wakes, then a pin reset, while asleep
        sleep <= 1'b1;
        wr(rsi_pkg::IDX_ICTL, 8'h80);
        wr(rsi_pkg::IDX_PCLO, 8'h10);
        ev(5'h01, 4'h8);
        rd(rsi_pkg::IDX_PCLO, 8'h04);
        chk("pc low", {24'h0, pc_low_o}, 32'h04);
        rd(rsi_pkg::IDX_PFLG, 8'h40);
        rd(rsi_pkg::IDX_STAT, 8'h10);
        chk("cause", {25'h0, cause_o}, 32'h40);
        wr(rsi_pkg::IDX_ICTL, 8'h00);
        wr(rsi_pkg::IDX_PFLG, 8'h00);
        wr(rsi_pkg::IDX_PCLO, 8'h10);
        ev(5'h01, 4'h4);
        rd(rsi_pkg::IDX_PCLO, 8'h11);
        rd(rsi_pkg::IDX_ICTL, 8'h04);
        rd(rsi_pkg::IDX_PFLG, 8'h00);
        wr(rsi_pkg::IDX_PFLG, 8'h40);
        ev(5'h01, 4'h2);
        rd(rsi_pkg::IDX_PFLG, 8'h40);
        rd(rsi_pkg::IDX_ICTL, 8'h06);
        rd(rsi_pkg::IDX_PCLO, 8'h12);
        ev(5'h04, 4'h0);
        rd(rsi_pkg::IDX_PCLO, 8'h13);
        rd(rsi_pkg::IDX_STAT, 8'h00);
        rd(rsi_pkg::IDX_PWR, 8'h00);
        chk("cause", {25'h0, cause_o}, 32'h20);
        ev(5'h02, 4'h0);
        rd(rsi_pkg::IDX_PCLO, 8'h00);
        rd(rsi_pkg::IDX_STAT, 8'h10);
        rd(rsi_pkg::IDX_PFLG, 8'h00);
        rd(rsi_pkg::IDX_ICTL, 8'h00);
        chk("cause", {25'h0, cause_o}, 32'h10);
        stop_test();
    end
endmodule

// [include/rsi_pkg.sv]
// ============================================================
// Functional notes
// - supply collapse is handled as power-on reset
// - interrupt wake with global enable loads vector
// - interrupt wake-up sets its source flag bits
// - comparator wake sets peripheral flag bit six
// - other wake sources leave bit six alone
// - brown-out reset clears power-control bit zero
// - resets other than brown-out and power-on preserve power-control bit zero
// - unimplemented bits always read as zero
package rsi_pkg;
    // ============================================================
    // reset and wake causes, one-hot
    typedef enum logic [6:0] {
        RSI_POR       = 7'h01,
        RSI_BOR       = 7'h02,
        RSI_DOG_RST   = 7'h04,
        RSI_PIN_RUN   = 7'h08,
        RSI_PIN_SLEEP = 7'h10,
        RSI_WAKE_DOG  = 7'h20,
        RSI_WAKE_IRQ  = 7'h40
    } rsi_cause_type;

    // ============================================================
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_INDIR  = 8'h00;
    localparam logic [7:0] IDX_TMR    = 8'h01;
    localparam logic [7:0] IDX_PCLO   = 8'h02;
    localparam logic [7:0] IDX_STAT   = 8'h03;
    localparam logic [7:0] IDX_PTR    = 8'h04;
    localparam logic [7:0] IDX_PA     = 8'h05;
    localparam logic [7:0] IDX_PB     = 8'h06;
    localparam logic [7:0] IDX_PCHI   = 8'h0a;
    localparam logic [7:0] IDX_ICTL   = 8'h0b;
    localparam logic [7:0] IDX_PFLG   = 8'h0c;
    localparam logic [7:0] IDX_CMP    = 8'h1f;
    localparam logic [7:0] IDX_OPT    = 8'h81;
    localparam logic [7:0] IDX_DIRA   = 8'h85;
    localparam logic [7:0] IDX_DIRB   = 8'h86;
    localparam logic [7:0] IDX_PEN    = 8'h8c;
    localparam logic [7:0] IDX_PWR    = 8'h8e;
    localparam logic [7:0] IDX_VREF   = 8'h9f;
    localparam logic [7:0] IDX_CAUSE  = 8'he0;
    localparam logic [7:0] IDX_WACC   = 8'he1;

    // ============================================================
    // storage slots
    localparam int NSLOT     = 17;
    localparam int SL_PCLO   = 1;
    localparam int SL_STAT   = 2;
    localparam int SL_ICTL   = 7;
    localparam int SL_PFLG   = 8;
    localparam int SL_PWR    = 14;
    localparam logic [7:0] SLOT_IDX [NSLOT] = '{IDX_TMR, IDX_PCLO, IDX_STAT, IDX_PTR,
        IDX_PA, IDX_PB, IDX_PCHI, IDX_ICTL, IDX_PFLG, IDX_CMP, IDX_OPT, IDX_DIRA,
        IDX_DIRB, IDX_PEN, IDX_PWR, IDX_VREF, IDX_WACC};
    // implemented bits; everything else stores and reads zero
    localparam logic [7:0] IMPL_MASK [NSLOT] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'h1f,
        8'hff, 8'h1f, 8'hff, 8'h40, 8'h3f, 8'hff, 8'h1f, 8'hff, 8'h40, 8'h03, 8'hef, 8'hff};
    // software-writable bits; time-out and power-down status are hardware only
    localparam logic [7:0] WR_MASK [NSLOT] = '{8'hff, 8'hff, 8'he7, 8'hff, 8'h1f,
        8'hff, 8'h1f, 8'hff, 8'h40, 8'h3f, 8'hff, 8'h1f, 8'hff, 8'h40, 8'h03, 8'hef, 8'hff};
    // power-on values, unknown bits defined as zero
    localparam logic [7:0] POR_VAL [NSLOT] = '{8'h00, 8'h00, 8'h18, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h1f, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00};
    // bits kept across other resets, and the value of the rest
    localparam logic [7:0] KEEP_MASK [NSLOT] = '{8'hff, 8'h00, 8'h1f, 8'hff, 8'h1f,
        8'hff, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03, 8'h00, 8'hff};
    localparam logic [7:0] HARD_VAL [NSLOT] = POR_VAL;

    // ============================================================
    // fields
    localparam int         GEN_BIT   = 7;
    localparam int         TO_BIT    = 4;
    localparam int         PD_BIT    = 3;
    localparam int         CMPF_BIT  = 6;
    localparam int         BORF_BIT  = 0;
    localparam logic [7:0] IRQ_VEC   = 8'h04;
endpackage

// [logic/rsi_top.sv]
module rsi_top (
    input  wire logic        clk_i,        // core clock, 40 MHz
    input  wire logic        rst_i,        // synchronous reset, treated as power-on
    input  wire logic        wb_cyc_i,     // bus cycle
    input  wire logic        wb_stb_i,     // bus strobe
    input  wire logic        wb_we_i,      // write enable
    input  wire logic [9:0]  wb_adr_i,     // byte address
    input  wire logic [3:0]  wb_sel_i,     // byte lanes, only lane 0 used
    input  wire logic [31:0] wb_dat_i,     // write data
    output logic      [31:0] wb_dat_o,     // read data
    output logic             wb_ack_o,     // bus acknowledge
    input  wire logic        por_evt_i,    // supply collapse pulse
    input  wire logic        bor_evt_i,    // brown-out reset pulse
    input  wire logic        wdt_evt_i,    // watchdog time-out pulse
    input  wire logic        pin_evt_i,    // external reset pin pulse
    input  wire logic        sleep_i,      // core is in sleep
    input  wire logic        wake_irq_i,   // interrupt wake pulse
    input  wire logic [3:0]  irq_src_i,    // port change, pin, timer, comparator
    output logic      [7:0]  pc_low_o,     // program counter low byte
    output logic      [6:0]  cause_o       // last cause, one-hot
);
    // ============================================================
    // cause decode, priority power-on > brown-out > watchdog > pin > wake
    function automatic logic idx_hit(input logic [7:0] a, input logic [7:0] idx);
        idx_hit = (a == idx);
    endfunction

    wire logic ev_por   = por_evt_i;
    wire logic ev_bor   = bor_evt_i & ~ev_por;
    wire logic hi_wdt   = ~ev_por & ~bor_evt_i;
    wire logic ev_wrst  = wdt_evt_i & ~sleep_i & hi_wdt;
    wire logic ev_wwake = wdt_evt_i & sleep_i & hi_wdt;
    wire logic hi_pin   = hi_wdt & ~wdt_evt_i;
    wire logic ev_prun  = pin_evt_i & ~sleep_i & hi_pin;
    wire logic ev_pslp  = pin_evt_i & sleep_i & hi_pin;
    wire logic ev_iwake = wake_irq_i & sleep_i & hi_pin & ~pin_evt_i;
    wire logic ev_hard  = ev_bor | ev_wrst | ev_prun | ev_pslp;
    wire logic ev_wake  = ev_wwake | ev_iwake;
    wire logic ev_any   = ev_por | ev_hard | ev_wake;
    wire logic [6:0] ev_vec = {ev_iwake, ev_wwake, ev_pslp, ev_prun, ev_wrst, ev_bor, ev_por};

    // ============================================================
    // bus decode; a write lands at the edge where the master sees ack
    wire logic [7:0] bus_idx = wb_adr_i[9:2];
    wire logic       bus_req = wb_cyc_i & wb_stb_i;
    wire logic       bus_wr  = bus_req & wb_we_i & wb_ack_o & wb_sel_i[0];
    wire logic [7:0] wdat    = wb_dat_i[7:0];

    logic [7:0] regs_r   [rsi_pkg::NSLOT];
    logic [7:0] regs_nxt [rsi_pkg::NSLOT];
    logic [7:0] base     [rsi_pkg::NSLOT];
    logic [7:0] rd_chain [rsi_pkg::NSLOT+1];
    rsi_pkg::rsi_cause_type cause_r;

    wire logic gen_en = regs_r[rsi_pkg::SL_ICTL][rsi_pkg::GEN_BIT];

    // ============================================================
    // values that depend on the cause
    wire logic [7:0] pc_b   = base[rsi_pkg::SL_PCLO];
    wire logic [7:0] stat_b = base[rsi_pkg::SL_STAT];
    wire logic [7:0] ictl_b = base[rsi_pkg::SL_ICTL];
    wire logic [7:0] pflg_b = base[rsi_pkg::SL_PFLG];
    wire logic [7:0] pwr_b  = base[rsi_pkg::SL_PWR];

    wire logic [7:0] pc_wake = (ev_iwake & gen_en) ? rsi_pkg::IRQ_VEC
                                                   : 8'(pc_b + 8'h01);
    wire logic to_hard = ev_pslp ? 1'b1 : ev_wrst ? 1'b0 : stat_b[rsi_pkg::TO_BIT];
    wire logic pd_hard = ev_pslp ? 1'b0 : stat_b[rsi_pkg::PD_BIT];
    wire logic [7:0] stat_hard = {3'b000, to_hard, pd_hard, stat_b[2:0]};
    wire logic [7:0] stat_wake = {stat_b[7:5], ev_iwake, 1'b0, stat_b[2:0]};
    wire logic [7:0] ictl_wake = ev_iwake ? (ictl_b | {5'h00, irq_src_i[2:0]})
                                          : ictl_b;
    wire logic cmp_set = ev_iwake & irq_src_i[3];
    wire logic [7:0] pflg_wake = cmp_set ? (pflg_b | 8'h40) : pflg_b;
    wire logic [7:0] pwr_hard = {pwr_b[7:1], pwr_b[rsi_pkg::BORF_BIT] & ~ev_bor};

    // ============================================================
    // per-slot next value; hardware events act on the value after a same-cycle write, which power-on discards and other resets keep only in their kept bits
    genvar s;
    generate
        for (s = 0; s < rsi_pkg::NSLOT; s++) begin : g_slot
            wire logic [7:0] wm  = rsi_pkg::WR_MASK[s];
            wire logic       hit = bus_wr & idx_hit(bus_idx, rsi_pkg::SLOT_IDX[s]);
            wire logic [7:0] gen_hard = (base[s] & rsi_pkg::KEEP_MASK[s])
                                      | rsi_pkg::HARD_VAL[s];
            wire logic [7:0] sp_hard;
            wire logic [7:0] sp_wake;
            assign base[s] = hit ? ((regs_r[s] & ~wm) | (wdat & wm)) : regs_r[s];
            if (s == rsi_pkg::SL_STAT) begin : g_st
                assign sp_hard = stat_hard;
                assign sp_wake = stat_wake;
            end else if (s == rsi_pkg::SL_PCLO) begin : g_pc
                assign sp_hard = 8'h00;
                assign sp_wake = pc_wake;
            end else if (s == rsi_pkg::SL_ICTL) begin : g_ic
                assign sp_hard = gen_hard;
                assign sp_wake = ictl_wake;
            end else if (s == rsi_pkg::SL_PFLG) begin : g_pf
                assign sp_hard = gen_hard;
                assign sp_wake = pflg_wake;
            end else if (s == rsi_pkg::SL_PWR) begin : g_pw
                assign sp_hard = pwr_hard;
                assign sp_wake = base[s];
            end else begin : g_gen
                assign sp_hard = gen_hard;
                assign sp_wake = base[s];
            end
            assign regs_nxt[s] = (ev_por ? rsi_pkg::POR_VAL[s]
                                : ev_hard ? sp_hard
                                : ev_wake ? sp_wake
                                : base[s]) & rsi_pkg::IMPL_MASK[s];
            assign rd_chain[s+1] = rd_chain[s]
                                 | (idx_hit(bus_idx, rsi_pkg::SLOT_IDX[s]) ? regs_r[s] : 8'h00);
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    regs_r[s] <= rsi_pkg::POR_VAL[s];
                end else begin
                    regs_r[s] <= regs_nxt[s];
                end
            end
        end
    endgenerate

    // ============================================================
    // read path; unmapped indices and the indirect port read zero
    assign rd_chain[0] = 8'h00;
    wire logic [7:0] rd_data = idx_hit(bus_idx, rsi_pkg::IDX_CAUSE) ? {1'b0, cause_r}
                                                                     : rd_chain[rsi_pkg::NSLOT];
    wire logic        ack_nxt = bus_req & ~wb_ack_o;
    wire logic [31:0] dat_nxt = ack_nxt ? {24'h000000, rd_data} : wb_dat_o;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
            cause_r  <= rsi_pkg::RSI_POR;
        end else begin
            wb_ack_o <= ack_nxt;
            wb_dat_o <= dat_nxt;
            if (ev_any) begin
                cause_r <= rsi_pkg::rsi_cause_type'(ev_vec);
            end
        end
    end

    // pc_low_o mirrors the counter register so it sits straight on a flip-flop
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pc_low_o <= 8'h00;
            cause_o  <= 7'h01;
        end else begin
            pc_low_o <= regs_nxt[rsi_pkg::SL_PCLO];
            cause_o  <= ev_any ? ev_vec : cause_o;
        end
    end

    // ============================================================
    // checks
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_bor_clears_flag: assert property (ev_bor |=> !regs_r[rsi_pkg::SL_PWR][0])
        else $error("brown-out did not clear power flag");
    a_other_keeps_flag: assert property ((ev_wrst | ev_prun | ev_pslp | ev_wake)
        |=> regs_r[rsi_pkg::SL_PWR][0] == $past(regs_r[rsi_pkg::SL_PWR][0]))
        else $error("power flag changed on non brown-out reset");
    a_por_loads_values: assert property (ev_por |=> regs_r[rsi_pkg::SL_STAT] == 8'h18
        && regs_r[rsi_pkg::SL_PWR] == 8'h00 && regs_r[10] == 8'hff)
        else $error("power-on values not loaded");
    a_hard_init_vals: assert property (ev_hard |=> regs_r[11] == 8'h1f
        && regs_r[12] == 8'hff && regs_r[rsi_pkg::SL_ICTL][7:1] == 7'h00)
        else $error("reset values not loaded");
    a_irq_vector_load: assert property (ev_iwake && gen_en |=> pc_low_o == 8'h04
        && regs_r[rsi_pkg::SL_PCLO] == 8'h04)
        else $error("interrupt vector not loaded");
    a_wake_sets_flag: assert property (ev_iwake && irq_src_i != 4'h0
        |=> (regs_r[rsi_pkg::SL_ICTL][2:0] != 3'b000) || regs_r[rsi_pkg::SL_PFLG][6])
        else $error("wake source flag not set");
    a_cmp_sets_bit: assert property (cmp_set |=> regs_r[rsi_pkg::SL_PFLG][6])
        else $error("comparator wake did not set bit six");
    a_cmp_bit_kept: assert property (ev_wake && !cmp_set && !bus_wr
        |=> $stable(regs_r[rsi_pkg::SL_PFLG][6]))
        else $error("bit six changed on other wake");
    a_unimpl_zero: assert property (regs_r[rsi_pkg::SL_PWR][7:2] == 6'h00
        && regs_r[rsi_pkg::SL_PFLG][5:0] == 6'h00 && wb_dat_o[31:8] == 24'h000000)
        else $error("unimplemented bits not zero");
    a_pc_reset_wake: assert property ((ev_hard |=> pc_low_o == 8'h00)
        and (ev_wwake && !bus_wr |=> regs_r[rsi_pkg::SL_PCLO]
             == 8'($past(regs_r[rsi_pkg::SL_PCLO]) + 8'h01)))
        else $error("program counter wrong after reset or wake");
    a_bus_ack_one: assert property (bus_req && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not a single cycle");

    // ============================================================
    // per-cause register checks; a same-cycle write is excluded where it may win

    a_irq_no_vector: assert property (ev_iwake && !gen_en && !bus_wr
        |=> regs_r[rsi_pkg::SL_PCLO] == 8'($past(regs_r[rsi_pkg::SL_PCLO]) + 8'h01))
        else $error("interrupt wake without enable did not increment");

    a_dog_rst_pc: assert property (ev_wrst |=> regs_r[rsi_pkg::SL_PCLO] == 8'h00)
        else $error("watchdog reset did not clear counter");

    a_pc_out_mirror: assert property (pc_low_o == regs_r[rsi_pkg::SL_PCLO])
        else $error("counter output differs from register");

    a_por_clears_pc: assert property (ev_por |=> pc_low_o == 8'h00)
        else $error("power-on did not clear counter");

    a_por_dir_ones: assert property (ev_por |=> regs_r[11] == 8'h1f
        && regs_r[12] == 8'hff)
        else $error("power-on direction values wrong");

    a_por_ictl_zero: assert property (ev_por |=> regs_r[rsi_pkg::SL_ICTL] == 8'h00
        && regs_r[rsi_pkg::SL_PFLG] == 8'h00)
        else $error("power-on interrupt values wrong");

    a_hard_opt_ones: assert property (ev_hard |=> regs_r[10] == 8'hff)
        else $error("option register not all ones");

    a_hard_pen_zero: assert property (ev_hard |=> regs_r[13] == 8'h00
        && regs_r[rsi_pkg::SL_PFLG] == 8'h00)
        else $error("peripheral enables or flags not cleared");

    a_hard_cmp_zero: assert property (ev_hard |=> regs_r[9] == 8'h00
        && regs_r[6] == 8'h00 && regs_r[15] == 8'h00)
        else $error("comparator, latch or reference not cleared");

    a_hard_keeps_data: assert property (ev_hard && !bus_wr
        |=> regs_r[0] == $past(regs_r[0]) && regs_r[3] == $past(regs_r[3]))
        else $error("timer or pointer changed on reset");

    a_status_upper_zero: assert property (ev_hard
        |=> regs_r[rsi_pkg::SL_STAT][7:5] == 3'b000)
        else $error("status upper bits not cleared");

    a_pin_sleep_status: assert property (ev_pslp
        |=> regs_r[rsi_pkg::SL_STAT][4:3] == 2'b10)
        else $error("pin reset in sleep status wrong");

    a_pin_run_status: assert property (ev_prun && !bus_wr
        |=> regs_r[rsi_pkg::SL_STAT][4:0] == $past(regs_r[rsi_pkg::SL_STAT][4:0]))
        else $error("pin reset in run changed status");

    a_dog_rst_status: assert property (ev_wrst
        |=> !regs_r[rsi_pkg::SL_STAT][rsi_pkg::TO_BIT])
        else $error("watchdog reset left time-out set");

    a_wake_clears_pd: assert property (ev_wake
        |=> !regs_r[rsi_pkg::SL_STAT][rsi_pkg::PD_BIT])
        else $error("wake left power-down set");

    a_irq_wake_to: assert property (ev_iwake
        |=> regs_r[rsi_pkg::SL_STAT][rsi_pkg::TO_BIT])
        else $error("interrupt wake left time-out clear");

    a_dog_wake_to: assert property (ev_wwake
        |=> !regs_r[rsi_pkg::SL_STAT][rsi_pkg::TO_BIT])
        else $error("watchdog wake left time-out set");

    a_dog_wake_flags: assert property (ev_wwake && !bus_wr
        |=> $stable(regs_r[rsi_pkg::SL_PFLG]))
        else $error("watchdog wake changed peripheral flags");

    a_iwake_bit_kept: assert property (ev_iwake && !irq_src_i[3] && !bus_wr
        |=> $stable(regs_r[rsi_pkg::SL_PFLG][6]))
        else $error("non comparator wake changed bit six");

    a_wake_keeps_cfg: assert property (ev_wake && !bus_wr
        |=> $stable(regs_r[10]) && $stable(regs_r[11]) && $stable(regs_r[6]))
        else $error("wake changed configuration registers");

    a_pen_unimpl: assert property (regs_r[13][7] == 1'b0
        && regs_r[13][5:0] == 6'h00)
        else $error("peripheral enable spare bits not zero");

    a_spare_bits_zero: assert property (regs_r[15][4] == 1'b0
        && regs_r[6][7:5] == 3'b000 && regs_r[11][7:5] == 3'b000)
        else $error("spare register bits not zero");

    a_cause_out_tracks: assert property (ev_any |=> cause_o == $past(ev_vec))
        else $error("cause output not updated");

    a_cause_out_holds: assert property (!ev_any |=> $stable(cause_o))
        else $error("cause output changed without event");

    a_cause_onehot: assert property ($onehot(cause_r))
        else $error("cause register not one-hot");

    a_ack_needs_req: assert property (wb_ack_o |-> $past(bus_req))
        else $error("ack without request");

    c_bor_seen:  cover property (ev_bor ##1 bus_req && !wb_we_i);
    c_cmp_wake:  cover property (cmp_set && gen_en);
    c_dog_wake:  cover property (ev_wwake);
    c_pin_sleep: cover property (ev_pslp);
    c_irq_plain: cover property (ev_iwake && !gen_en);
endmodule
